// [src/mpp_pkg.sv]
// package: constants, map and types of the multifunction pin port
package mpp_pkg;
  // ==========================================
  // sizes
  localparam int NPIN = 32;
  localparam int NEI = 19;   // interrupt index space, slot 10 is the rtc alarm
  localparam int NFLT = 8;   // filtered inputs
  localparam int FLT_BASE = 11;
  localparam int NPERI = 16;
  localparam int RTC_BIT = 10;
  localparam int AW = 8;
  // ==========================================
  // register offsets
  localparam logic [AW-1:0] A_FN_LO = 8'h00;
  localparam logic [AW-1:0] A_FN_MID = 8'h04;
  localparam logic [AW-1:0] A_FN_UP = 8'h08;
  localparam logic [AW-1:0] A_DAT = 8'h0C;
  localparam logic [AW-1:0] A_PU = 8'h10;
  localparam logic [AW-1:0] A_TRIG0 = 8'h18;
  localparam logic [AW-1:0] A_TRIG1 = 8'h1C;
  localparam logic [AW-1:0] A_FLT = 8'h20;
  localparam logic [AW-1:0] A_MASK = 8'h24;
  localparam logic [AW-1:0] A_PEND = 8'h28;
  localparam logic [AW-1:0] A_PPU = 8'h2C;
  localparam logic [AW-1:0] A_ALIVE = 8'h30;
  localparam logic [AW-1:0] A_SDAT = 8'h34;
  localparam logic [AW-1:0] A_SOE = 8'h38;
  localparam logic [AW-1:0] A_SPU = 8'h3C;
  localparam logic [AW-1:0] A_SPDAT = 8'h40;
  localparam logic [AW-1:0] A_SPOE = 8'h44;
  localparam logic [AW-1:0] A_SPPU = 8'h48;
  localparam logic [AW-1:0] A_RSTC = 8'h4C;
  // ==========================================
  // field layouts and codes
  localparam int FN_LO_W = 22;  // pins 10..0
  localparam int FN_MID_W = 16; // pins 18..11
  localparam int FN_UP_W = 26;  // pins 31..19
  localparam logic [1:0] FN_IN = 2'h0;
  localparam logic [1:0] FN_OUT = 2'h1;
  localparam logic [1:0] FN_ALT1 = 2'h2;
  localparam logic [1:0] FN_ALT2 = 2'h3;
  localparam logic [31:0] EINT_PINS = 32'h0007FBFF;
  localparam logic [NEI-1:0] WAKE_SRC = 19'h007FF; // inputs 9..0 and rtc slot
  localparam int NWAKE = 10;
  localparam int TRIG1_N = 8;
  localparam int AL_POR = 0;
  localparam int AL_WAKE = 1;
  localparam int AL_BATF = 2;
  localparam logic [2:0] AL_RST = 3'h1;
  localparam int FLT_LEN_LSB = 8;
  localparam int FLT_W = 8;
  localparam int RC_W = 16;
  localparam logic [RC_W-1:0] RC_RST = 16'h00FF;
  // ==========================================
  // types
  typedef enum logic [1:0] {MD_RUN, MD_SLEEP, MD_WAKE} mpp_mode_t;
  typedef struct packed {
    logic [NPIN-1:0] out;
    logic [NPIN-1:0] oe_n;
    logic [NPIN-1:0] pu_en;
  } mpp_pad_t;
  typedef struct packed {
    logic [NPIN-1:0] a_out;
    logic [NPIN-1:0] a_oe;
    logic [NPIN-1:0] b_out;
    logic [NPIN-1:0] b_oe;
  } mpp_alt_t;
  typedef struct packed {
    logic [NPERI-1:0] out;
    logic [NPERI-1:0] oe;
    logic [NPERI-1:0] pu_en;
  } mpp_peri_t;
endpackage : mpp_pkg

// [src/mpp_top.sv]
// module: multifunction pin port with wake-up and apb registers
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - thirty-two pins, each with selectable function
// - two-bit field per pin selects function
// - output pins drive written data bit
// - input pins read back pin level
// - pull-up bit zero enables, one disables
// - pull-up independent of pin function
// - five trigger kinds per interrupt input
// - request needs interrupt mode and unmasked
// - pending sets even when masked
// - eight inputs pass a digital filter
// - only ten lowest inputs and rtc alarm wake chip
// - wake ignores mask, pins need interrupt mode
// - battery fault low blocks all wake
// - wake cause recorded, rtc alarm included
// - status shows reset kind, battery fault
// - sleep data comes from sleep register
// - sleep drive enable from sleep register
// - sleep pull-ups from sleep register
// - peripheral pull-up zero enables
// - peripheral pins use sleep registers asleep
// - compare value sets wake reset length
// - function pins read back pin level
module mpp_top
  import mpp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [mpp_pkg::AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [mpp_pkg::NPIN-1:0] pin_in,
  output mpp_pkg::mpp_pad_t pad,
  input wire mpp_pkg::mpp_alt_t alt,
  output logic [mpp_pkg::NPIN-1:0] alt_pin_level,
  input wire mpp_pkg::mpp_peri_t peri_in,
  output mpp_pkg::mpp_peri_t peri,
  input wire logic battery_fault_low,
  input wire logic rtc_alarm,
  input wire logic sleep_req,
  output logic [mpp_pkg::NEI-1:0] ext_irq_req,
  output logic wake_event,
  output logic wake_reset,
  output logic in_sleep
);
  import mpp_pkg::*;

  // ==========================================
  // state
  typedef struct packed {
    mpp_mode_t md;                    // run, sleep or wake reset hold
    logic [2*NPIN-1:0] fn;            // function select, two bits per pin
    logic [NPIN-1:0] dat;             // normal data
    logic [NPIN-1:0] pu;              // normal pull-up disable
    logic [NPIN-1:0] s_dat;           // sleep data
    logic [NPIN-1:0] s_oe;            // sleep drive enable, 1 drives
    logic [NPIN-1:0] s_pu;            // sleep pull-up disable
    logic [NPERI-1:0] p_pu;           // peripheral pull-up disable
    logic [NPERI-1:0] s_pdat;
    logic [NPERI-1:0] s_poe;
    logic [NPERI-1:0] s_ppu;
    logic [NEI-1:0][2:0] trig;        // trigger kind per input
    logic [NEI-1:0] mask;             // 1 masks the request
    logic [NEI-1:0] pend;             // sticky pending flags
    logic [NEI-1:0] flt_val;          // filtered level
    logic [NEI-1:0] prev;             // filtered level one cycle back
    logic [15:0] flt_ctl;             // enables and filter length
    logic [NFLT-1:0][FLT_W-1:0] flt_cnt;
    logic [2:0] alive;                // reset kind and battery fault
    logic [RC_W-1:0] rst_cmp;
    logic [RC_W-1:0] rst_cnt;
    logic [NPIN-1:0] s1;              // synchroniser, first stage
    logic [NPIN-1:0] s2;              // synchroniser, second stage
    logic b1;
    logic b2;
    logic [31:0] rdata;
    logic err;
    logic [NEI-1:0] irq;
    logic wake;
    mpp_pad_t pad;
    mpp_peri_t peri;
  } mpp_st_t;

  mpp_st_t q;  // registered state
  mpp_st_t d;  // next state

  // ==========================================
  // helpers
  // trigger match for one input
  function automatic logic trig_hit(input logic [2:0] t, input logic v,
                                    input logic p);
    logic r;
    r = 1'b0;
    if (t[2:1] == 2'h0) begin
      r = t[0] ? v : ~v;
    end else if (t[2:1] == 2'h1) begin
      r = p & ~v;
    end else if (t[2:1] == 2'h2) begin
      r = ~p & v;
    end else begin
      r = p ^ v;
    end
    return r;
  endfunction : trig_hit

  // ==========================================
  // next state
  always_comb begin
    logic wr;
    logic setup;
    logic slp;
    logic [NEI-1:0] mode;
    logic [NEI-1:0] hit;
    logic [NEI-1:0] set;
    logic [NEI-1:0] clr;
    logic [2:0] aclr;
    logic [NPIN-1:0] oe;
    logic [NPIN-1:0] od;
    logic [NPIN-1:0] rd_dat;
    logic [1:0] f;
    int idx;
    wr = psel & penable & pwrite;
    setup = psel & ~penable;
    slp = 1'b0;
    mode = '0;
    hit = '0;
    set = '0;
    clr = '0;
    aclr = '0;
    oe = '0;
    od = '0;
    rd_dat = '0;
    f = FN_IN;
    idx = 0;
    d = q;
    d.wake = 1'b0;
    // two-stage synchronisers for pins and battery fault
    d.s1 = pin_in;
    d.s2 = q.s1;
    d.b1 = battery_fault_low;
    d.b2 = q.b1;

    d.flt_val = q.s2[NEI-1:0];
    for (int k = 0; k < NFLT; k++) begin
      idx = FLT_BASE + k;
      if (q.flt_ctl[k]) begin
        d.flt_val[idx] = q.flt_val[idx];
        if (q.s2[idx] == q.flt_val[idx]) begin
          d.flt_cnt[k] = '0;
        end else if (q.flt_cnt[k] >= q.flt_ctl[FLT_LEN_LSB +: FLT_W]) begin
          d.flt_val[idx] = q.s2[idx];
          d.flt_cnt[k] = '0;
        end else begin
          d.flt_cnt[k] = q.flt_cnt[k] + 8'h01;
        end
      end else begin
        d.flt_cnt[k] = '0;
      end
    end
    d.prev = q.flt_val;

    for (int i = 0; i < NEI; i++) begin
      mode[i] = EINT_PINS[i] && (q.fn[2*i +: 2] == FN_ALT1);
      hit[i] = trig_hit(q.trig[i], q.flt_val[i], q.prev[i]);
    end
    slp = (q.md == MD_SLEEP);
    if (slp) begin
      // only wake sources are live asleep
      set = hit & mode & WAKE_SRC;
      // rtc alarm records its own bit
      set[RTC_BIT] = rtc_alarm;
      if (!q.b2) begin
        set = '0;
      end
    end else begin
      set = hit & mode;
    end

    // ----- apb setup phase: answer is registered here
    if (setup) begin
      d.err = 1'b0;
      d.rdata = '0;
      for (int i = 0; i < NPIN; i++) begin
        f = q.fn[2*i +: 2];
        // input level read; function pins show pin too
        rd_dat[i] = (f == FN_OUT) ? q.dat[i] : q.s2[i];
      end
      unique case (paddr)
        A_FN_LO: d.rdata[FN_LO_W-1:0] = q.fn[FN_LO_W-1:0];
        A_FN_MID: d.rdata[FN_MID_W-1:0] = q.fn[FN_LO_W +: FN_MID_W];
        A_FN_UP: d.rdata[FN_UP_W-1:0] = q.fn[FN_LO_W+FN_MID_W +: FN_UP_W];
        A_DAT: d.rdata = rd_dat;
        A_PU: d.rdata = q.pu;
        A_TRIG0: d.rdata[3*NWAKE-1:0] = q.trig[NWAKE-1:0];
        A_TRIG1: d.rdata[3*TRIG1_N-1:0] = q.trig[NEI-1:FLT_BASE];
        A_FLT: d.rdata[15:0] = q.flt_ctl;
        A_MASK: d.rdata[NEI-1:0] = q.mask;
        A_PEND: d.rdata[NEI-1:0] = q.pend;
        A_PPU: d.rdata[NPERI-1:0] = q.p_pu;
        // reset kind and battery fault visible
        A_ALIVE: d.rdata[2:0] = q.alive;
        A_SDAT: d.rdata = q.s_dat;
        A_SOE: d.rdata = q.s_oe;
        A_SPU: d.rdata = q.s_pu;
        A_SPDAT: d.rdata[NPERI-1:0] = q.s_pdat;
        A_SPOE: d.rdata[NPERI-1:0] = q.s_poe;
        A_SPPU: d.rdata[NPERI-1:0] = q.s_ppu;
        A_RSTC: d.rdata[RC_W-1:0] = q.rst_cmp;
        default: d.err = 1'b1;  // unmapped reads zero with error
      endcase
    end

    // ----- apb access phase writes
    if (wr) begin
      unique case (paddr)
        A_FN_LO: d.fn[FN_LO_W-1:0] = pwdata[FN_LO_W-1:0];
        A_FN_MID: d.fn[FN_LO_W +: FN_MID_W] = pwdata[FN_MID_W-1:0];
        A_FN_UP: d.fn[FN_LO_W+FN_MID_W +: FN_UP_W] = pwdata[FN_UP_W-1:0];
        A_DAT: d.dat = pwdata;
        A_PU: d.pu = pwdata;
        A_TRIG0: d.trig[NWAKE-1:0] = pwdata[3*NWAKE-1:0];
        A_TRIG1: d.trig[NEI-1:FLT_BASE] = pwdata[3*TRIG1_N-1:0];
        A_FLT: d.flt_ctl = pwdata[15:0];
        A_MASK: d.mask = pwdata[NEI-1:0];
        A_PEND: clr = pwdata[NEI-1:0];      // write one to clear
        A_PPU: d.p_pu = pwdata[NPERI-1:0];
        A_ALIVE: aclr = pwdata[2:0];        // write one to clear
        A_SDAT: d.s_dat = pwdata;
        A_SOE: d.s_oe = pwdata;
        A_SPU: d.s_pu = pwdata;
        A_SPDAT: d.s_pdat = pwdata[NPERI-1:0];
        A_SPOE: d.s_poe = pwdata[NPERI-1:0];
        A_SPPU: d.s_ppu = pwdata[NPERI-1:0];
        A_RSTC: d.rst_cmp = pwdata[RC_W-1:0];
        default: d.rst_cmp = q.rst_cmp;     // unmapped write ignored
      endcase
    end

    // pending flags: a new event beats a clear in the same cycle
    d.pend = (q.pend & ~clr) | set;
    // request only in interrupt mode and unmasked
    d.irq = d.pend & ~q.mask & mode;
    d.irq[RTC_BIT] = 1'b0;
    // battery fault is sticky; set wins over clear
    d.alive = q.alive & ~aclr;
    if (!q.b2) begin
      d.alive[AL_BATF] = 1'b1;
    end

    // ----- power mode sequencing
    unique case (q.md)
      MD_RUN: begin
        if (sleep_req) begin
          d.md = MD_SLEEP;
        end
      end
      MD_SLEEP: begin
        // wake on any live source, mask not consulted
        if (|(set & WAKE_SRC)) begin
          d.md = MD_WAKE;
          d.wake = 1'b1;
          d.rst_cnt = '0;
          d.alive[AL_WAKE] = 1'b1;
          d.alive[AL_POR] = 1'b0;
        end
      end
      MD_WAKE: begin
        // reset held until count reaches compare
        if (q.rst_cnt >= q.rst_cmp) begin
          d.md = MD_RUN;
        end else begin
          d.rst_cnt = q.rst_cnt + 16'h0001;
        end
      end
    endcase

    // ----- pad drive, registered
    for (int i = 0; i < NPIN; i++) begin
      f = q.fn[2*i +: 2];
      // each pin muxed to one function
      unique case (f)
        FN_IN: begin
          oe[i] = 1'b0;
          od[i] = q.dat[i];
        end
        FN_OUT: begin
          // output pin drives its data bit
          oe[i] = 1'b1;
          od[i] = q.dat[i];
        end
        FN_ALT1: begin
          // interrupt pins only sample
          oe[i] = EINT_PINS[i] ? 1'b0 : alt.a_oe[i];
          od[i] = alt.a_out[i];
        end
        FN_ALT2: begin
          oe[i] = alt.b_oe[i];
          od[i] = alt.b_out[i];
        end
      endcase
    end
    // sleep settings held until wake reset ends
    if (q.md != MD_RUN) begin
      d.pad.out = q.s_dat;
      d.pad.oe_n = ~q.s_oe;
      d.pad.pu_en = ~q.s_pu;
      d.peri.out = q.s_pdat;
      d.peri.oe = q.s_poe;
      d.peri.pu_en = ~q.s_ppu;
    end else begin
      d.pad.out = od;
      d.pad.oe_n = ~oe;
      d.pad.pu_en = ~q.pu;
      d.peri.out = peri_in.out;
      d.peri.oe = peri_in.oe;
      d.peri.pu_en = ~q.p_pu;
    end
  end

  // ==========================================
  // registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.md <= MD_RUN;
      q.mask <= '1;
      q.alive <= AL_RST;
      q.rst_cmp <= RC_RST;
      q.pad.oe_n <= '1;
      q.pad.pu_en <= '1;
      q.peri.pu_en <= '1;
      // battery fault line idles high: a zero here would log a false fault
      q.b1 <= 1'b1;
      q.b2 <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ==========================================
  // outputs
  assign prdata = q.rdata;
  assign pslverr = q.err & psel & penable;
  // zero wait states; answer prepared in setup
  assign pready = 1'b1;
  assign pad = q.pad;
  assign peri = q.peri;
  assign alt_pin_level = q.s2;
  assign ext_irq_req = q.irq;
  assign wake_event = q.wake;
  assign wake_reset = (q.md == MD_WAKE);
  assign in_sleep = (q.md == MD_SLEEP);
endmodule : mpp_top
`default_nettype wire

// [verif/mpp_board.sv]
// board model: pin levels from pad drive, board drive and pull-ups
`timescale 1ns/1ps
`default_nettype none
module mpp_board
  import mpp_pkg::*;
(
  input wire logic pclk,
  input wire mpp_pkg::mpp_pad_t pad,
  input wire logic [31:0] drv_en,
  input wire logic [31:0] drv_val,
  output logic [31:0] pin_in
);
  // ========
  // an undriven line without pull-up toggles, so no luck
  logic flt_q = 1'b0;
  always @(posedge pclk) flt_q <= ~flt_q;
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      if (!pad.oe_n[i]) pin_in[i] = pad.out[i];
      else if (drv_en[i]) pin_in[i] = drv_val[i];
      else pin_in[i] = pad.pu_en[i] | flt_q;
    end
  end
endmodule : mpp_board
`default_nettype wire

// [verif/mpp_top_sva.sv]
// checker: port-level properties of the pin port
`timescale 1ns/1ps
`default_nettype none
module mpp_top_sva
  import mpp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic battery_fault_low,
  input wire logic rtc_alarm,
  input wire logic sleep_req,
  input wire logic [mpp_pkg::NEI-1:0] ext_irq_req,
  input wire logic wake_event,
  input wire logic wake_reset,
  input wire logic in_sleep
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ========
  // counts the cycles of the wake reset hold
  logic [9:0] hold_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) hold_q <= 10'h000;
    else hold_q <= wake_reset ? hold_q + 10'h001 : 10'h000;
  end
  a_rtc_no_irq: assert property (ext_irq_req[RTC_BIT] == 1'b0)
    else $error("rtc slot raised a request");
  a_sleep_entry: assert property (!in_sleep && !wake_reset && sleep_req |=> in_sleep)
    else $error("sleep not entered");
  a_wake_once: assert property (wake_event |=> !wake_event)
    else $error("wake longer than a cycle");
  a_wake_asleep: assert property (wake_event |-> $past(in_sleep))
    else $error("wake outside sleep");
  a_wake_hold: assert property (wake_event |-> ##[0:1] wake_reset)
    else $error("no reset hold after wake");
  a_hold_len: assert property ($fell(wake_reset) |-> hold_q == 10'h100)
    else $error("reset hold length wrong");
  a_fault_block: assert property ((!battery_fault_low) [*4] ##0 in_sleep |=> !wake_event)
    else $error("wake during battery fault");
  a_rtc_wake: assert property (battery_fault_low [*4] ##0 (in_sleep && rtc_alarm) |-> ##[1:2] wake_event)
    else $error("alarm did not wake");
endmodule : mpp_top_sva
bind mpp_top mpp_top_sva u_mpp_top_sva (.pclk(pclk), .presetn(presetn),
  .battery_fault_low(battery_fault_low), .rtc_alarm(rtc_alarm), .sleep_req(sleep_req),
  .ext_irq_req(ext_irq_req), .wake_event(wake_event), .wake_reset(wake_reset), .in_sleep(in_sleep));
`default_nettype wire

// [verif/test_multifunction_pin_port_with_wakeup.sv]
// testbench: registers, pins, interrupts and sleep of the pin port
`timescale 1ns/1ps
`default_nettype none
module test_multifunction_pin_port_with_wakeup;
  import mpp_pkg::*;
  // ========
  // design signals, board drive, scoreboard
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic battery_fault_low = 1'b1, rtc_alarm = 1'b0, sleep_req = 1'b0;
  logic pready, pslverr, wake_event, wake_reset, in_sleep;
  logic [AW-1:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, pin_in, drv_en = 32'h0, drv_val = 32'h0, alt_lvl;
  logic [31:0] rs = 32'h0000001D, dat, pu, sv [6];
  logic [NEI-1:0] ext_irq_req;
  logic [32:0] note;
  logic [32:0] expq [$];
  mpp_pad_t pad;
  mpp_alt_t alt = '0;
  mpp_peri_t peri_in = '0, peri;
  int num_errors = 0, total_checks = 0, wakes = 0;
  always #25 pclk = ~pclk;
  mpp_top u_mpp_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_in(pin_in), .pad(pad), .alt(alt), .alt_pin_level(alt_lvl), .peri_in(peri_in), .peri(peri),
    .battery_fault_low(battery_fault_low), .rtc_alarm(rtc_alarm), .sleep_req(sleep_req),
    .ext_irq_req(ext_irq_req), .wake_event(wake_event), .wake_reset(wake_reset), .in_sleep(in_sleep));
  mpp_board u_mpp_board (.pclk(pclk), .pad(pad), .drv_en(drv_en), .drv_val(drv_val), .pin_in(pin_in));
  // ========
  // helpers
  function logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction : rnd
  task test_done();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // one apb transfer; a read leaves its expected {error, data} in the queue
  task apb(input logic w, input logic [AW-1:0] a, input logic [31:0] d, input logic [32:0] e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) expq.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      num_errors++;
      test_done();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // settle: let edges land, then look at the falling edge
  task look(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask : look
  // bounded wait on in_sleep (ws=0) or wake_reset (ws=1)
  task wt(input bit ws, input logic lvl, input int lim);
    int n;
    n = 0;
    while ((ws ? wake_reset : in_sleep) !== lvl) begin
      @(posedge pclk);
      n++;
      if (n > lim) begin
        num_errors++;
        test_done();
      end
    end
  endtask : wt
  task nap();
    sleep_req <= 1'b1;
    wt(0, 1'b1, 20);
    sleep_req <= 1'b0;
  endtask : nap
  // ========
  // read checker: oldest note against each completed read
  always @(posedge pclk) begin
    if (wake_event === 1'b1) wakes++;
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      note = expq.pop_front();
      chk(prdata, note[31:0]);
      chk({31'h0, pslverr}, {31'h0, note[32]});
    end
  end
  // ========
  // main sequence
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, A_FN_LO, 32'h0, 33'h0);
    apb(1'b0, A_MASK, 32'h0, 33'h0007FFFF);
    apb(1'b0, A_ALIVE, 32'h0, 33'h1);
    apb(1'b0, A_RSTC, 32'h0, 33'hFF);
    apb(1'b0, 8'h14, 32'h0, 33'h100000000);
    dat = rnd();
    pu = rnd();
    apb(1'b1, A_FN_LO, 32'h00000055, 33'h0);
    apb(1'b1, A_DAT, dat, 33'h0);
    apb(1'b1, A_PU, pu, 33'h0);
    apb(1'b1, A_PPU, pu, 33'h0);
    drv_en <= 32'hFFFFFFF0;
    drv_val <= rnd();
    look(5);
    chk(pad.oe_n, 32'hFFFFFFF0);
    chk(pad.out & 32'hF, dat & 32'hF);
    chk(pad.pu_en, ~pu);
    chk({16'h0, peri.pu_en}, {16'h0, ~pu[15:0]});
    chk(alt_lvl, pin_in);
    apb(1'b0, A_DAT, 32'h0, {1'b0, drv_val[31:4], dat[3:0]});
    // pin 0 into interrupt mode, rising edge
    drv_en <= 32'hFFFFFFFF;
    drv_val <= 32'h0;
    // trigger first, so the default low-level setting never pends
    apb(1'b1, A_TRIG0, 32'h00000004, 33'h0);
    apb(1'b1, A_FN_LO, 32'h00000002, 33'h0);
    drv_val <= 32'h1;
    look(8);
    chk({13'h0, ext_irq_req}, 32'h0);
    apb(1'b0, A_PEND, 32'h0, 33'h1);
    apb(1'b1, A_MASK, 32'h0007FFFE, 33'h0);
    look(3);
    chk({13'h0, ext_irq_req}, 32'h1);
    apb(1'b1, A_PEND, 32'h1, 33'h0);
    apb(1'b0, A_PEND, 32'h0, 33'h0);
    apb(1'b1, A_MASK, 32'h0007FFFF, 33'h0);
    // input 11 rising, filter enabled with length 8
    apb(1'b1, A_TRIG1, 32'h00000004, 33'h0);
    apb(1'b1, A_FLT, 32'h00000801, 33'h0);
    apb(1'b1, A_FN_MID, 32'h00000002, 33'h0);
    look(4);
    drv_val <= 32'h00000801;
    look(3);
    drv_val <= 32'h00000001;
    look(12);
    apb(1'b0, A_PEND, 32'h0, 33'h0);
    drv_val <= 32'h00000801;
    look(20);
    apb(1'b0, A_PEND, 32'h0, 33'h800);
    apb(1'b1, A_PEND, 32'h00000800, 33'h0);
    for (int i = 0; i < 6; i++) begin
      sv[i] = rnd() & (i == 1 ? 32'hFFFFFFFE : 32'hFFFFFFFF);
      apb(1'b1, A_SDAT + 8'(4 * i), sv[i], 33'h0);
    end
    drv_val <= 32'h0;
    nap();
    look(3);
    chk(pad.out, sv[0]);
    chk(pad.oe_n, ~sv[1]);
    chk(pad.pu_en, ~sv[2]);
    chk({peri.out, peri.oe}, {sv[3][15:0], sv[4][15:0]});
    chk({16'h0, peri.pu_en}, {16'h0, ~sv[5][15:0]});
    @(posedge pclk);
    battery_fault_low <= 1'b0;
    look(5);
    drv_val <= 32'h1;
    look(8);
    chk(32'(wakes) + {31'h0, in_sleep}, 32'h1);
    @(posedge pclk);
    battery_fault_low <= 1'b1;
    drv_val <= 32'h0;
    look(6);
    drv_val <= 32'h1;
    wt(0, 1'b0, 20);
    wt(1, 1'b0, 400);
    look(2);
    chk(32'(wakes), 32'h1);
    chk(pad.oe_n, 32'hFFFFFFFF);
    chk(pad.pu_en, ~pu);
    nap();
    rtc_alarm <= 1'b1;
    wt(0, 1'b0, 20);
    rtc_alarm <= 1'b0;
    wt(1, 1'b0, 400);
    apb(1'b0, A_PEND, 32'h0, 33'h401);
    apb(1'b0, A_ALIVE, 32'h0, 33'h6);
    look(2);
    test_done();
  end
endmodule : test_multifunction_pin_port_with_wakeup
`default_nettype wire
